// File: rtl/keyed_watchdog_map.svh
`ifndef KEYED_WATCHDOG_MAP_SVH
`define KEYED_WATCHDOG_MAP_SVH

// Register addresses
`define WD_KEY_ADDR 16'hFF99
`define WD_MODE_ADDR 16'hFF98

// Restart key values
`define WD_KEY_VALUE 8'hAC
`define WD_KEY_READ 8'h9A

// Mode register layout and reset value
`define WD_MODE_RESET 8'h67
`define WD_MODE_TOP 3'h3
`define WD_MODE_TOP_MSB 7
`define WD_MODE_TOP_LSB 5
`define WD_CS_HI_BIT 4
`define WD_CS_LO_BIT 3
`define WD_PSEL_MSB 2
`define WD_PSEL_LSB 0

// Overflow exponents for period select zero, and the largest exponent
`define WD_RING_BASE_EXP 5'h0B
`define WD_X1_BASE_EXP 5'h0D
`define WD_EXP_MAX 5'h14

`endif

// File: rtl/keyed_watchdog_pkg.sv
package keyed_watchdog_pkg;

    typedef enum {
        WD_RUN,
        WD_SW_STOPPED
    } wd_state_type;

endpackage

// File: rtl/keyed_watchdog_timer.sv
// Contract
// - Correct key write clears counter, counting continues
// - Key register reads fixed value always
// - Wrong key while running causes reset
// - Bit access to key causes reset
// - Reset deferred until count clock runs
// - Counter overflow causes internal reset
// - Second mode write while running resets
// - Software-stopped watchdog ignores all faults
// - After reset: ring clock, longest period
// - Any mode write clears counter
// - Fixed build ignores clock-select bits
// - Fixed build counts always, never stops
// - Stoppable build: ring, X1, or stopped
// - Upper select bit set stops watchdog
// - Stoppable build pauses in HALT/STOP
// - X1 CPU and X1 count wait settling
// - Ring CPU, X1 count: settle or switch
// - Ring count resumes at once after STOP
// - Select: 00 ring, 01 X1, 1x stop
// - Period 2^11..2^18 ring, 2^13..2^20 X1
`timescale 1ns/1ps
`default_nettype none
`include "keyed_watchdog_map.svh"

module keyed_watchdog_timer
    import keyed_watchdog_pkg::*;
#(
    parameter bit STOPPABLE = 1'b1,
    parameter int CNT_W = 21
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register access port
    input wire logic [15:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic regBitAccess,
    output logic [7:0] regRdData,
    // Count clock pins
    input wire logic ringClkIn,
    input wire logic x1ClkIn,
    // Standby and clock status from the system controller
    input wire logic haltMode,
    input wire logic stopMode,
    input wire logic cpuOnX1,
    input wire logic oscSettleDone,
    // Internal reset request
    output logic wdtReset
);

    logic [7:0] rdData_r;
    logic wdtReset_r;
    wd_state_type state_r;
    logic modeWritten_r;
    logic clkSelHi_r;
    logic clkSelLo_r;
    logic [2:0] periodSel_r;
    logic [CNT_W-1:0] cnt_r;
    logic pending_r;
    logic settleWait_r;
    logic cpuX1AtStop_r;
    logic stopMode_d;
    logic [2:0] ringSync_r;
    logic [2:0] x1Sync_r;

    logic keyWr;
    logic keyBit;
    logic modeWr;
    logic goodKey;
    logic badEvent;
    logic srcX1;
    logic paused;
    logic countOn;
    logic tick;
    logic [4:0] ovExp;
    logic [CNT_W-1:0] lastCount;
    logic overflow;
    logic stopExit;

    // Reset image kept as a constant so its fields can be picked apart
    localparam logic [7:0] MODE_RESET = `WD_MODE_RESET;

    assign regRdData = rdData_r;
    assign wdtReset = wdtReset_r;

    // Decode of CPU accesses
    assign keyWr = regWr && (regAddr == `WD_KEY_ADDR);
    assign keyBit = regBitAccess && (regAddr == `WD_KEY_ADDR);
    assign modeWr = regWr && (regAddr == `WD_MODE_ADDR);
    assign goodKey = keyWr && (regWrData == `WD_KEY_VALUE);

    // A software-stopped watchdog never raises a reset
    assign badEvent = (state_r == WD_RUN) && ((keyWr && !goodKey) || keyBit
        || (modeWr && modeWritten_r));

    assign srcX1 = STOPPABLE && !clkSelHi_r && clkSelLo_r;

    // Fixed build keeps counting through every standby mode
    // For an X1 count clock the STOP exit edge itself is held too, before the wait flag is up
    assign stopExit = !stopMode && stopMode_d;
    assign paused = STOPPABLE && (haltMode || stopMode || settleWait_r
        || (stopExit && srcX1));
    assign countOn = (state_r == WD_RUN) && !paused;

    // Edge found between second and third stage; first stage feeds only the second
    assign tick = countOn && (srcX1 ? (x1Sync_r[1] && !x1Sync_r[2])
                                    : (ringSync_r[1] && !ringSync_r[2]));

    assign ovExp = (srcX1 ? `WD_X1_BASE_EXP : `WD_RING_BASE_EXP) + {2'h0, periodSel_r};
    assign lastCount = CNT_W'((CNT_W'(1) << ovExp) - CNT_W'(1));
    assign overflow = tick && (cnt_r == lastCount);

    // Count clock synchronisers
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ringSync_r <= 3'h0;
            x1Sync_r <= 3'h0;
        end
        else
        begin
            ringSync_r <= {ringSync_r[1:0], ringClkIn};
            x1Sync_r <= {x1Sync_r[1:0], x1ClkIn};
        end
    end

    // Read data: key reads a constant, mode reads its stored value
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdData_r <= 8'h00;
        else if (regRd && (regAddr == `WD_KEY_ADDR))
            rdData_r <= `WD_KEY_READ;
        else if (regRd && (regAddr == `WD_MODE_ADDR))
            rdData_r <= {`WD_MODE_TOP, clkSelHi_r, clkSelLo_r, periodSel_r};
        else if (regRd)
            rdData_r <= 8'h00;
    end

    // Mode register and run state
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modeWritten_r <= 1'b0;
            clkSelHi_r <= MODE_RESET[`WD_CS_HI_BIT];
            clkSelLo_r <= MODE_RESET[`WD_CS_LO_BIT];
            periodSel_r <= MODE_RESET[`WD_PSEL_MSB:`WD_PSEL_LSB];
            state_r <= WD_RUN;
        end
        else if (modeWr && !modeWritten_r)
        begin
            // Only one write is ever taken; top bits always read back fixed
            modeWritten_r <= 1'b1;
            periodSel_r <= regWrData[`WD_PSEL_MSB:`WD_PSEL_LSB];
            if (STOPPABLE)
            begin
                clkSelHi_r <= regWrData[`WD_CS_HI_BIT];
                clkSelLo_r <= regWrData[`WD_CS_LO_BIT];
                if (regWrData[`WD_CS_HI_BIT])
                    state_r <= WD_SW_STOPPED;
            end
        end
    end

    // Watchdog counter
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (modeWr || goodKey)
            cnt_r <= '0;
        else if (tick)
            cnt_r <= cnt_r + CNT_W'(1);
    end

    // Wake-up hold for an X1 count clock after STOP
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stopMode_d <= 1'b0;
            cpuX1AtStop_r <= 1'b0;
            settleWait_r <= 1'b0;
        end
        else
        begin
            stopMode_d <= stopMode;
            if (stopMode && !stopMode_d)
                cpuX1AtStop_r <= cpuOnX1;
            if (STOPPABLE && stopExit && srcX1)
                settleWait_r <= 1'b1;
            else if (oscSettleDone || (!cpuX1AtStop_r && cpuOnX1))
                settleWait_r <= 1'b0;
        end
        // Ring count clock never waits
    end

    // Fault reset: held off while the count clock is stopped
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_r <= 1'b0;
            wdtReset_r <= 1'b0;
        end
        else
        begin
            if (badEvent && !countOn)
                pending_r <= 1'b1;
            if ((badEvent && countOn) || (pending_r && countOn) || overflow)
                wdtReset_r <= 1'b1;
        end
    end

    // Checks
    sequence seqFault;
        badEvent && countOn;
    endsequence

    sequence seqResetUp;
        ##1 wdtReset_r;
    endsequence

    AST_KEY_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        goodKey |=> (cnt_r == '0))
        else $error("Counter not cleared by key");

    AST_KEY_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regRd && regAddr == `WD_KEY_ADDR) |=> (regRdData == `WD_KEY_READ))
        else $error("Key register read value wrong");

    AST_FAULT_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seqFault |-> seqResetUp)
        else $error("Fault did not raise reset");

    AST_BIT_ACCESS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (keyBit && state_r == WD_RUN && countOn) |=> wdtReset_r)
        else $error("Bit access did not raise reset");

    AST_HOLD_OFF: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(wdtReset_r) |-> $past(countOn))
        else $error("Reset raised while count clock stopped");

    AST_OVERFLOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (tick && cnt_r == lastCount) |=> wdtReset_r)
        else $error("Overflow did not raise reset");

    AST_SECOND_MODE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (modeWr && modeWritten_r && state_r == WD_RUN && countOn) |=> wdtReset_r)
        else $error("Second mode write did not raise reset");

    AST_SW_STOP_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == WD_SW_STOPPED && !wdtReset_r) |=> !wdtReset_r && state_r == WD_SW_STOPPED)
        else $error("Stopped watchdog raised reset or restarted");

    AST_MODE_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        modeWr |=> (cnt_r == '0))
        else $error("Mode write did not clear counter");

    AST_FIXED_CLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !STOPPABLE |-> (!srcX1 && state_r == WD_RUN))
        else $error("Fixed build left ring clock or stopped");

    AST_PAUSE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (STOPPABLE && (haltMode || stopMode) && !modeWr && !goodKey) |=> $stable(cnt_r))
        else $error("Counter moved during standby");

    sequence seqStopExitX1;
        STOPPABLE && stopExit && srcX1;
    endsequence

    sequence seqSettleEnd;
        settleWait_r && !stopExit && (oscSettleDone || (!cpuX1AtStop_r && cpuOnX1));
    endsequence

    AST_AFTER_RESET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !modeWritten_r |-> (periodSel_r == MODE_RESET[`WD_PSEL_MSB:`WD_PSEL_LSB] && !srcX1))
        else $error("Reset mode not ring clock with longest period");

    AST_MODE_READ: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (regRd && regAddr == `WD_MODE_ADDR && !modeWritten_r) |=> (regRdData == `WD_MODE_RESET))
        else $error("Mode register reset value wrong");

    AST_PENDING_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (badEvent && !countOn) |=> pending_r)
        else $error("Fault during stopped clock not remembered");

    AST_PENDING_FIRE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (pending_r && countOn) |=> wdtReset_r)
        else $error("Deferred fault did not raise reset");

    AST_RESET_STICKY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wdtReset_r |=> wdtReset_r)
        else $error("Internal reset request dropped");

    AST_FIXED_RUNS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !STOPPABLE |-> (state_r == WD_RUN && !paused))
        else $error("Fixed build paused or stopped");

    AST_STOP_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (STOPPABLE && modeWr && !modeWritten_r && regWrData[`WD_CS_HI_BIT])
        |=> (state_r == WD_SW_STOPPED))
        else $error("Upper select bit did not stop watchdog");

    AST_X1_SELECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (STOPPABLE && modeWr && !modeWritten_r && !regWrData[`WD_CS_HI_BIT]
        && regWrData[`WD_CS_LO_BIT]) |=> srcX1)
        else $error("Select 01 did not pick X1 clock");

    AST_PERIOD_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (ovExp >= `WD_RING_BASE_EXP) && (ovExp <= `WD_EXP_MAX))
        else $error("Overflow exponent out of range");

    AST_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ovExp < CNT_W)
        else $error("Counter too narrow for period");

    AST_SETTLE_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seqStopExitX1 |=> settleWait_r)
        else $error("X1 count clock did not wait after STOP");

    AST_SETTLE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (settleWait_r && !modeWr && !goodKey) |=> $stable(cnt_r))
        else $error("Counter moved during settle wait");

    AST_SETTLE_END: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seqSettleEnd |=> !settleWait_r)
        else $error("Settle wait did not end");

    AST_RING_NO_WAIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !srcX1 |-> !settleWait_r)
        else $error("Ring count clock waited after STOP");

    AST_STOPPED_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == WD_SW_STOPPED && !modeWr && !goodKey) |=> $stable(cnt_r))
        else $error("Stopped watchdog kept counting");

endmodule // keyed_watchdog_timer
`default_nettype wire

// File: verification/keyed_watchdog_timer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module keyed_watchdog_timer_tb;
    localparam logic [2:0] WR = 3'b100;
    localparam logic [2:0] RD = 3'b010;
    localparam logic [2:0] BT = 3'b001;
    localparam logic [15:0] KEY = 16'hFF99;
    localparam logic [15:0] MODE = 16'hFF98;
    logic sysClk = 1'b0;
    logic rstN = 1'b0;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic regBitAccess = 1'b0;
    logic ringClkIn = 1'b0;
    logic haltMode = 1'b0;
    logic x1ClkIn = 1'b0;
    logic stopMode = 1'b0;
    logic cpuOnX1 = 1'b0;
    logic oscSettleDone = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWrData = 8'h00;
    logic [7:0] regRdData;
    logic wdtReset;
    int errCount = 0;
    int nChecks = 0;

    keyed_watchdog_timer dut_u (.sys_clk(sysClk), .rst_n(rstN), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regBitAccess(regBitAccess),
        .regRdData(regRdData), .ringClkIn(ringClkIn), .x1ClkIn(x1ClkIn), .haltMode(haltMode),
        .stopMode(stopMode), .cpuOnX1(cpuOnX1), .oscSettleDone(oscSettleDone),
        .wdtReset(wdtReset));

    always #2 sysClk = ~sysClk;

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic acc(input logic [2:0] kind, input logic [15:0] a, input logic [7:0] d);
        @(negedge sysClk);
        regAddr = a;
        regWrData = d;
        {regWr, regRd, regBitAccess} = kind;
        @(negedge sysClk);
        {regWr, regRd, regBitAccess} = 3'b000;
    endtask

    task automatic doReset();
        @(negedge sysClk);
        rstN = 1'b0;
        haltMode = 1'b0;
        stopMode = 1'b0;
        cpuOnX1 = 1'b0;
        repeat (6) @(negedge sysClk);
        rstN = 1'b1;
    endtask

    // Slow enough that the three-flop synchroniser sees every edge
    task automatic ticks(input int n, input bit onX1 = 1'b0);
        repeat (n)
        begin
            if (onX1)
                x1ClkIn = 1'b1;
            else
                ringClkIn = 1'b1;
            repeat (2) @(negedge sysClk);
            x1ClkIn = 1'b0;
            ringClkIn = 1'b0;
            repeat (2) @(negedge sysClk);
        end
    endtask

    task automatic rstSeen(input logic e, input string what);
        logic seen;
        seen = 1'b0;
        repeat (12)
        begin
            @(negedge sysClk);
            seen = seen | wdtReset;
        end
        check(what, {7'h00, seen}, {7'h00, e});
    endtask

    task automatic testRead();
        doReset();
        acc(RD, KEY, 8'h00);
        check("key reset", regRdData, 8'h9A);
        acc(WR, KEY, 8'hAC);
        acc(RD, KEY, 8'h00);
        check("key read", regRdData, 8'h9A);
        acc(RD, MODE, 8'h00);
        check("mode reset", regRdData, 8'h67);
        acc(RD, 16'hFF00, 8'h00);
        check("unmapped", regRdData, 8'h00);
        rstSeen(1'b0, "good key");
        $display("test read done");
    endtask

    task automatic testOverflow();
        doReset();
        ticks(10);
        acc(WR, MODE, 8'h60);
        ticks(2047);
        rstSeen(1'b0, "mode clear");
        ticks(1);
        rstSeen(1'b1, "overflow");
        $display("test overflow done");
    endtask

    task automatic testKey();
        doReset();
        acc(WR, MODE, 8'h60);
        ticks(10);
        acc(WR, KEY, 8'hAC);
        ticks(2047);
        rstSeen(1'b0, "key clear");
        ticks(1);
        rstSeen(1'b1, "period");
        $display("test key done");
    endtask

    task automatic testFaults();
        for (int k = 0; k < 3; k++)
        begin
            doReset();
            if (k == 0) acc(WR, KEY, 8'hAB);
            if (k == 1) acc(BT, KEY, 8'h00);
            if (k == 2) acc(WR, MODE, 8'h60);
            if (k == 2) acc(WR, MODE, 8'h60);
            rstSeen(1'b1, "fault");
        end
        $display("test faults done");
    endtask

    task automatic testStopped();
        doReset();
        acc(WR, MODE, 8'h70);
        acc(WR, KEY, 8'h00);
        acc(BT, KEY, 8'h00);
        acc(WR, MODE, 8'h60);
        ticks(2100);
        rstSeen(1'b0, "stopped");
        doReset();
        acc(WR, MODE, 8'h68);
        ticks(2100);
        rstSeen(1'b0, "x1 select");
        $display("test stopped done");
    endtask

    task automatic testHalt();
        doReset();
        haltMode = 1'b1;
        acc(WR, KEY, 8'h00);
        rstSeen(1'b0, "deferred");
        haltMode = 1'b0;
        rstSeen(1'b1, "resumed");
        doReset();
        acc(WR, MODE, 8'h60);
        ticks(2000);
        haltMode = 1'b1;
        ticks(100);
        haltMode = 1'b0;
        ticks(20);
        stopMode = 1'b1;
        ticks(100);
        stopMode = 1'b0;
        ticks(27);
        rstSeen(1'b0, "halt hold");
        ticks(1);
        rstSeen(1'b1, "halt kept");
        $display("test halt done");
    endtask

    task automatic testSettle();
        doReset();
        acc(WR, MODE, 8'h68);
        ticks(4000, 1'b1);
        cpuOnX1 = 1'b1;
        stopMode = 1'b1;
        ticks(50, 1'b1);
        stopMode = 1'b0;
        ticks(50, 1'b1);
        oscSettleDone = 1'b1;
        @(negedge sysClk);
        oscSettleDone = 1'b0;
        ticks(2000, 1'b1);
        cpuOnX1 = 1'b0;
        stopMode = 1'b1;
        ticks(50, 1'b1);
        stopMode = 1'b0;
        ticks(50, 1'b1);
        cpuOnX1 = 1'b1;
        ticks(2191, 1'b1);
        rstSeen(1'b0, "settle hold");
        ticks(1, 1'b1);
        rstSeen(1'b1, "settle resume");
        $display("test settle done");
    endtask

    task automatic closeOut();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        testRead();
        testOverflow();
        testKey();
        testFaults();
        testStopped();
        testHalt();
        testSettle();
        closeOut();
    end
endmodule // keyed_watchdog_timer_tb
`default_nettype wire
